// ===== pkg/fpanel_pkg.sv
package fpanel_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned DEB_TIME_US = 5000;
  localparam int unsigned BLINK_TIME_US = 250000;
  localparam int unsigned DEB_CYC = (DEB_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BLINK_CYC = (BLINK_TIME_US * 1000) / CLK_NS;
  localparam int unsigned NCARD_DEF = 16;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] TIME_OFS = 8'h08;
  localparam int unsigned CTRL_W = 6;
  localparam int unsigned CTRL_READ_BIT = 0;
  localparam int unsigned CTRL_LOOP_BIT = 1;
  localparam int unsigned CTRL_RESTART_BIT = 2;
  localparam int unsigned CTRL_VSGEN_BIT = 3;
  localparam int unsigned CTRL_RATE_LSB = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Buttons and display
  // ----------------------------------------------------------------
  localparam int unsigned NBTN = 4;
  localparam int unsigned BTN_START = 0;
  localparam int unsigned BTN_PAUSE = 1;
  localparam int unsigned BTN_RESET = 2;
  localparam int unsigned BTN_MUTE = 3;
  localparam logic [3:0] TIME_COL = 4'h5;
  localparam logic [3:0] RATE_COL = 4'he;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_DASH = 8'h2d;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [31:0] TXT_GEN = "Gen ";
  localparam logic [31:0] TXT_GENV = "Gen*";
  localparam logic [31:0] TXT_READ = "Read";
  localparam logic [31:0] TXT_STOP = "Stop";
  localparam logic [31:0] TXT_RUN = "Run ";
  localparam logic [31:0] TXT_PAUS = "Paus";
  localparam logic [31:0] TXT_WAIT = "Wait";
  localparam logic [15:0] TXT_R24 = "24";
  localparam logic [15:0] TXT_R25 = "25";
  localparam logic [15:0] TXT_R30 = "30";
  localparam logic [15:0] TXT_R29 = "29";

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CS_STOP = 3'h0,
    CS_PLAY = 3'h1,
    CS_HOLD = 3'h3,
    CS_SEARCH = 3'h2,
    CS_INIT = 3'h6,
    CS_FAULT = 3'h7
  } card_st_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic generating;
    logic out_active;
    logic idle;
    logic end_hit;
    logic vs_detect;
    logic vs_lock;
    logic fault;
    logic busy;
    logic tc_valid;
    logic [31:0] tc;
  } eng_st_t;

  typedef struct packed {
    logic start;
    logic listen;
    logic restart;
    logic pause;
    logic halt;
    logic ignore;
  } eng_cmd_t;

  typedef struct packed {
    logic power;
    logic fault;
    logic vsync;
    logic gen;
    logic ready;
    logic run;
    logic pause;
    logic stop;
    logic mute;
  } leds_t;

endpackage

// ===== rtl/front_panel.sv
// How it works
// - Nine unit lamps: power, fault, sync lock, generating, ready, run, pause, stop, mute.
// - Fault lamp lit whenever a fault is detected.
// - Sync lamp lit only while video sync is present and locked.
// - Generating lamp lit while the timecode engine generates.
// - Ready lamp lit while the unit can accept commands.
// - Run lamp lit whenever timecode output is active.
// - Pause lamp lit after pause press while loop-end pause is pending.
// - Stop lamp lit while the engine is idle.
// - Start press starts generation, or listening in read mode.
// - Start during generation restarts the clock only when enabled.
// - Pause acts only in generate-and-loop mode, pausing at next loop end.
// - Reset press halts generation, or ignores timecode in read mode.
// - Reset press also stops every playback card.
// - Mute press toggles muting; mute lamp lit, card lamps red.
// - Display is 2x16: mode, time, state and frame rate fields.
// - Mode field shows generate, generate with sync lock, or read.
// - Dashes replace time digits when no timecode is present.
// - Card lamp colour and blink follow the card state.
// - Test press on a stopped card plays its lowest file.
// - Test press on a playing card stops it.
// - Test press on a faulted card clears the fault.
`timescale 1ns/1ns
module front_panel #(
  parameter int unsigned NCARD = fpanel_pkg::NCARD_DEF,
  parameter int unsigned DEB_CYC = fpanel_pkg::DEB_CYC,
  parameter int unsigned BLINK_CYC = fpanel_pkg::BLINK_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic [fpanel_pkg::NBTN-1:0] BTN_I,
  input wire logic [NCARD-1:0] TEST_BTN_I,
  input wire fpanel_pkg::eng_st_t ENG_I,
  input wire fpanel_pkg::card_st_t [NCARD-1:0] CARD_ST_I,
  input wire logic [4:0] DISP_ADDR_I,
  input wire fpanel_pkg::axil_req_t AXI_REQ_I,
  output fpanel_pkg::axil_rsp_t AXI_RSP_O,
  output fpanel_pkg::leds_t LED_O,
  output fpanel_pkg::eng_cmd_t ENG_CMD_O,
  output logic STOP_ALL_O,
  output logic MUTE_O,
  output logic [NCARD-1:0] PLAY_FIRST_O,
  output logic [NCARD-1:0] STOP_O,
  output logic [NCARD-1:0] CLR_FAULT_O,
  output logic [NCARD-1:0] LAMP_RED_O,
  output logic [NCARD-1:0] LAMP_GRN_O,
  output logic [7:0] DISP_CHAR_O
);

  // ----------------------------------------------------------------
  // Sizes and elaboration checks
  // ----------------------------------------------------------------
  localparam int unsigned NB = fpanel_pkg::NBTN + NCARD;
  localparam int unsigned DCW = $clog2(DEB_CYC + 1);
  localparam int unsigned BCW = $clog2(BLINK_CYC + 1);

  if (NCARD < 1 || NCARD > 16) begin : g_chk_card
    $error("NCARD must be 1 to 16");
  end
  if (DEB_CYC < 2 || BLINK_CYC < 2) begin : g_chk_cnt
    $error("Timebase counts must be at least 2");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NB-1:0] sync1;
    logic [NB-1:0] sync2;
    logic [NB-1:0] samp;
    logic [NB-1:0] deb;
    logic [DCW-1:0] deb_cnt;
    logic [BCW-1:0] blk_cnt;
    logic blink;
    logic mute;
    logic pend;
    logic [fpanel_pkg::CTRL_W-1:0] ctrl;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    fpanel_pkg::leds_t led;
    fpanel_pkg::eng_cmd_t eng;
    logic stop_all;
    logic [NCARD-1:0] play_first;
    logic [NCARD-1:0] stop;
    logic [NCARD-1:0] clr;
    logic [NCARD-1:0] lamp_r;
    logic [NCARD-1:0] lamp_g;
    logic [7:0] disp;
    fpanel_pkg::axil_rsp_t rsp;
  } state_t;

  state_t q;
  state_t d;
  logic [NB-1:0] press;
  logic tick;
  logic is_read;
  logic any_fault;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic aok;
  logic wok;
  logic [7:0] waddr;
  logic [31:0] wdat;
  logic [3:0] wstb;
  logic [31:0] mode_txt;
  logic [31:0] st_txt;
  logic [15:0] rate_txt;
  logic [1:0] lamp;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Lamp colour {red, green} of one card
  function automatic logic [1:0] card_lamp(input fpanel_pkg::card_st_t st,
                                           input logic mute, input logic blink);
    card_lamp = 2'h0;
    unique case (st)
      fpanel_pkg::CS_STOP: card_lamp = 2'h0;
      fpanel_pkg::CS_PLAY: card_lamp = 2'h1;
      fpanel_pkg::CS_HOLD: card_lamp = 2'h3;
      fpanel_pkg::CS_SEARCH: card_lamp = {1'h0, blink};
      fpanel_pkg::CS_INIT: card_lamp = {1'h0, blink};
      fpanel_pkg::CS_FAULT: card_lamp = {blink, 1'h0};
      default: card_lamp = 2'h0;
    endcase
    if (mute && st != fpanel_pkg::CS_FAULT) begin
      card_lamp = 2'h2;
    end
  endfunction

  // Character at one display cell; a[4] selects the bottom row
  function automatic logic [7:0] disp_char(input logic [4:0] a, input logic [31:0] mtxt,
                                           input logic [31:0] stxt, input logic [15:0] rtxt,
                                           input logic tcv, input logic [31:0] tc);
    logic [3:0] col;
    logic [3:0] c;
    logic [3:0] k;
    col = a[3:0];
    c = col - fpanel_pkg::TIME_COL;
    k = c - c / 4'h3;
    disp_char = fpanel_pkg::CH_SP;
    if (col < 4'h4) begin
      disp_char = a[4] ? stxt[8*(3-col) +: 8] : mtxt[8*(3-col) +: 8];
    end else if (!a[4] && col >= fpanel_pkg::TIME_COL) begin
      if (c == 4'h2 || c == 4'h5 || c == 4'h8) begin
        disp_char = fpanel_pkg::CH_COLON;
      end else if (!tcv) begin
        disp_char = fpanel_pkg::CH_DASH;
      end else begin
        disp_char = {4'h3, tc[4*(7-k) +: 4]};
      end
    end else if (a[4] && col >= fpanel_pkg::RATE_COL) begin
      disp_char = rtxt[8*(15-col) +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // Button synchroniser and sampled debounce
    d.sync1 = {TEST_BTN_I, BTN_I};
    d.sync2 = q.sync1;
    tick = q.deb_cnt == DCW'(DEB_CYC - 1);
    d.deb_cnt = tick ? '0 : q.deb_cnt + 1'h1;
    if (tick) begin
      d.samp = q.sync2;
      d.deb = (q.sync2 & q.samp) | (q.deb & (q.sync2 | q.samp));
    end
    press = d.deb & ~q.deb;

    // Shared blink timebase
    if (q.blk_cnt == BCW'(BLINK_CYC - 1)) begin
      d.blk_cnt = '0;
      d.blink = ~q.blink;
    end else begin
      d.blk_cnt = q.blk_cnt + 1'h1;
    end

    // Timecode engine commands
    is_read = q.ctrl[fpanel_pkg::CTRL_READ_BIT];
    d.eng = '0;
    d.stop_all = 1'h0;
    if (press[fpanel_pkg::BTN_START]) begin
      if (is_read) begin
        d.eng.listen = 1'h1;
      end else if (ENG_I.generating) begin
        d.eng.restart = q.ctrl[fpanel_pkg::CTRL_RESTART_BIT];
      end else begin
        d.eng.start = 1'h1;
      end
    end
    if (press[fpanel_pkg::BTN_RESET]) begin
      d.eng.halt = ~is_read;
      d.eng.ignore = is_read;
      d.stop_all = 1'h1;
    end

    // Loop-end pause request; a new press wins over a clear
    d.eng.pause = q.pend & ENG_I.end_hit;
    d.pend = (press[fpanel_pkg::BTN_PAUSE] & ~is_read & ENG_I.generating
              & q.ctrl[fpanel_pkg::CTRL_LOOP_BIT])
             | (q.pend & ~ENG_I.end_hit & ENG_I.generating
                & ~press[fpanel_pkg::BTN_RESET]);

    // Mute toggle
    d.mute = q.mute ^ press[fpanel_pkg::BTN_MUTE];

    // Card test buttons and lamps
    any_fault = 1'h0;
    for (int i = 0; i < NCARD; i++) begin
      d.play_first[i] = 1'h0;
      d.stop[i] = 1'h0;
      d.clr[i] = 1'h0;
      if (press[fpanel_pkg::NBTN + i]) begin
        d.play_first[i] = CARD_ST_I[i] == fpanel_pkg::CS_STOP;
        d.stop[i] = CARD_ST_I[i] == fpanel_pkg::CS_PLAY;
        d.clr[i] = CARD_ST_I[i] == fpanel_pkg::CS_FAULT;
      end
      lamp = card_lamp(CARD_ST_I[i], d.mute, d.blink);
      d.lamp_r[i] = lamp[1];
      d.lamp_g[i] = lamp[0];
      any_fault = any_fault | (CARD_ST_I[i] == fpanel_pkg::CS_FAULT);
    end

    // Unit status lamps
    d.led.power = 1'h1;
    d.led.fault = ENG_I.fault | any_fault;
    d.led.vsync = ENG_I.vs_detect & ENG_I.vs_lock;
    d.led.gen = ENG_I.generating;
    d.led.ready = ~ENG_I.busy;
    d.led.run = ENG_I.out_active;
    d.led.pause = d.pend;
    d.led.stop = ENG_I.idle;
    d.led.mute = d.mute;

    // Display fields
    if (is_read) begin
      mode_txt = fpanel_pkg::TXT_READ;
    end else if (q.ctrl[fpanel_pkg::CTRL_VSGEN_BIT] && ENG_I.vs_lock) begin
      mode_txt = fpanel_pkg::TXT_GENV;
    end else begin
      mode_txt = fpanel_pkg::TXT_GEN;
    end
    if (ENG_I.idle) begin
      st_txt = fpanel_pkg::TXT_STOP;
    end else if (q.pend) begin
      st_txt = fpanel_pkg::TXT_PAUS;
    end else if (ENG_I.out_active) begin
      st_txt = fpanel_pkg::TXT_RUN;
    end else begin
      st_txt = fpanel_pkg::TXT_WAIT;
    end
    unique case (q.ctrl[fpanel_pkg::CTRL_RATE_LSB +: 2])
      2'h0: rate_txt = fpanel_pkg::TXT_R24;
      2'h1: rate_txt = fpanel_pkg::TXT_R25;
      2'h2: rate_txt = fpanel_pkg::TXT_R30;
      2'h3: rate_txt = fpanel_pkg::TXT_R29;
    endcase
    d.disp = disp_char(DISP_ADDR_I, mode_txt, st_txt, rate_txt,
                       ENG_I.tc_valid, ENG_I.tc);

    // AXI4-Lite write: address and data in either order
    aw_fire = AXI_REQ_I.awvalid & q.rsp.awready;
    w_fire = AXI_REQ_I.wvalid & q.rsp.wready;
    if (aw_fire) begin
      d.aw_have = 1'h1;
      d.awaddr = AXI_REQ_I.awaddr[7:0];
    end
    if (w_fire) begin
      d.w_have = 1'h1;
      d.wdata = AXI_REQ_I.wdata;
      d.wstrb = AXI_REQ_I.wstrb;
    end
    aok = q.aw_have | aw_fire;
    wok = q.w_have | w_fire;
    waddr = aw_fire ? AXI_REQ_I.awaddr[7:0] : q.awaddr;
    wdat = w_fire ? AXI_REQ_I.wdata : q.wdata;
    wstb = w_fire ? AXI_REQ_I.wstrb : q.wstrb;
    if (q.rsp.bvalid && AXI_REQ_I.bready) begin
      d.rsp.bvalid = 1'h0;
    end
    if (aok && wok && !q.rsp.bvalid) begin
      d.aw_have = 1'h0;
      d.w_have = 1'h0;
      d.rsp.bvalid = 1'h1;
      d.rsp.bresp = fpanel_pkg::RESP_OKAY;
      if (waddr == fpanel_pkg::CTRL_OFS) begin
        if (wstb[0]) begin
          d.ctrl = wdat[fpanel_pkg::CTRL_W-1:0];
        end
      end else if (waddr != fpanel_pkg::STAT_OFS && waddr != fpanel_pkg::TIME_OFS) begin
        d.rsp.bresp = fpanel_pkg::RESP_SLVERR;
      end
    end
    d.rsp.awready = ~d.aw_have & ~d.rsp.bvalid;
    d.rsp.wready = ~d.w_have & ~d.rsp.bvalid;

    // AXI4-Lite read
    ar_fire = AXI_REQ_I.arvalid & q.rsp.arready;
    if (q.rsp.rvalid && AXI_REQ_I.rready) begin
      d.rsp.rvalid = 1'h0;
      d.rsp.arready = 1'h1;
    end
    if (ar_fire) begin
      d.rsp.rvalid = 1'h1;
      d.rsp.arready = 1'h0;
      d.rsp.rresp = fpanel_pkg::RESP_OKAY;
      d.rsp.rdata = '0;
      unique case (AXI_REQ_I.araddr[7:0])
        fpanel_pkg::CTRL_OFS: d.rsp.rdata[fpanel_pkg::CTRL_W-1:0] = q.ctrl;
        fpanel_pkg::STAT_OFS: d.rsp.rdata[9:0] = {q.eng.pause, q.led};
        fpanel_pkg::TIME_OFS: d.rsp.rdata = ENG_I.tc;
        default: d.rsp.rresp = fpanel_pkg::RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= '0;
      q.ctrl <= fpanel_pkg::CTRL_RST;
      q.rsp.awready <= 1'h1;
      q.rsp.wready <= 1'h1;
      q.rsp.arready <= 1'h1;
      q.led.power <= 1'h1;
    end else if (CE_I) begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign AXI_RSP_O = q.rsp;
  assign LED_O = q.led;
  assign ENG_CMD_O = q.eng;
  assign STOP_ALL_O = q.stop_all;
  assign MUTE_O = q.mute;
  assign PLAY_FIRST_O = q.play_first;
  assign STOP_O = q.stop;
  assign CLR_FAULT_O = q.clr;
  assign LAMP_RED_O = q.lamp_r;
  assign LAMP_GRN_O = q.lamp_g;
  assign DISP_CHAR_O = q.disp;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  property p_fault;
    CE_I && ENG_I.fault |=> LED_O.fault;
  endproperty
  a_fault: assert property (p_fault) else $error("fault lamp dark");

  property p_vsync;
    CE_I && !(ENG_I.vs_detect && ENG_I.vs_lock) |=> !LED_O.vsync;
  endproperty
  a_vsync: assert property (p_vsync) else $error("sync lamp lit unlocked");

  property p_run;
    CE_I && RST_N_I |=> LED_O.run == $past(ENG_I.out_active);
  endproperty
  a_run: assert property (p_run) else $error("run lamp wrong");

  property p_stop;
    CE_I && RST_N_I |=> LED_O.stop == $past(ENG_I.idle);
  endproperty
  a_stop: assert property (p_stop) else $error("stop lamp wrong");

  property p_pend;
    CE_I && q.pend && ENG_I.generating && !ENG_I.end_hit
      && !press[fpanel_pkg::BTN_RESET] |=> LED_O.pause;
  endproperty
  a_pend: assert property (p_pend) else $error("pause lamp dropped");

  property p_pause_mode;
    CE_I && !q.pend && press[fpanel_pkg::BTN_PAUSE]
      && !q.ctrl[fpanel_pkg::CTRL_LOOP_BIT] |=> !LED_O.pause;
  endproperty
  a_pause_mode: assert property (p_pause_mode) else $error("pause outside loop");

  property p_restart;
    CE_I && press[fpanel_pkg::BTN_START] && ENG_I.generating && !is_read
      && !q.ctrl[fpanel_pkg::CTRL_RESTART_BIT] |=> !ENG_CMD_O.restart && !ENG_CMD_O.start;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not enabled");

  property p_reset;
    CE_I && press[fpanel_pkg::BTN_RESET] |=> STOP_ALL_O && (ENG_CMD_O.halt != ENG_CMD_O.ignore);
  endproperty
  a_reset: assert property (p_reset) else $error("reset press not acted");

  property p_mute;
    CE_I && press[fpanel_pkg::BTN_MUTE] |=> MUTE_O != $past(MUTE_O) && LED_O.mute == MUTE_O;
  endproperty
  a_mute: assert property (p_mute) else $error("mute did not toggle");

  property p_lamp;
    CE_I && MUTE_O && !press[fpanel_pkg::BTN_MUTE]
      && CARD_ST_I[0] != fpanel_pkg::CS_FAULT |=> LAMP_RED_O[0] && !LAMP_GRN_O[0];
  endproperty
  a_lamp: assert property (p_lamp) else $error("muted lamp not red");

  property p_pulse;
    CE_I && ENG_CMD_O.start |=> !ENG_CMD_O.start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");

  c_start: cover property (CE_I && press[fpanel_pkg::BTN_START] ##1 ENG_CMD_O.start);
  c_loop_pause: cover property (LED_O.pause ##[1:1000] ENG_CMD_O.pause);
  c_mute: cover property (CE_I && press[fpanel_pkg::BTN_MUTE] ##1 MUTE_O);
  c_test: cover property (CE_I && press[fpanel_pkg::NBTN] ##1 (PLAY_FIRST_O[0] || STOP_O[0]));

endmodule

// ===== sim/eng_model.sv
`timescale 1ns/1ns
module eng_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire fpanel_pkg::eng_cmd_t cmd_i,
  input wire logic lock_i,
  input wire logic fault_i,
  input wire logic hit_i,
  output fpanel_pkg::eng_st_t st_o
);
  logic gen_q;
  // Generation starts on start or restart, ends on halt or loop-end pause
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gen_q <= 1'b0;
    end else if (cmd_i.halt || cmd_i.pause) begin
      gen_q <= 1'b0;
    end else if (cmd_i.start || cmd_i.restart) begin
      gen_q <= 1'b1;
    end
  end
  // Status levels seen by the panel; loop end only while generating
  assign st_o = '{generating: gen_q, out_active: gen_q, idle: !gen_q, end_hit: hit_i && gen_q,
    vs_detect: lock_i, vs_lock: lock_i, fault: fault_i, busy: 1'b0, tc_valid: gen_q,
    tc: 32'h01020304};
endmodule

// ===== sim/tb_front_panel.sv
`timescale 1ns/1ns
module tb_front_panel;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int NC = 2;
  typedef struct packed {
    fpanel_pkg::card_st_t st;
    logic [1:0] r;
    logic [1:0] g;
    logic [9:0] c;
  } row_t;
  row_t rows [6] = '{'{fpanel_pkg::CS_STOP, 2'h0, 2'h0, 10'h080},
    '{fpanel_pkg::CS_PLAY, 2'h0, 2'h1, 10'h100}, '{fpanel_pkg::CS_HOLD, 2'h1, 2'h1, 10'h000},
    '{fpanel_pkg::CS_SEARCH, 2'h0, 2'h2, 10'h000}, '{fpanel_pkg::CS_INIT, 2'h0, 2'h2, 10'h000},
    '{fpanel_pkg::CS_FAULT, 2'h2, 2'h0, 10'h200}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] btn = 4'h0;
  logic [NC-1:0] tbtn = '0;
  fpanel_pkg::card_st_t [NC-1:0] cst = {NC{fpanel_pkg::CS_STOP}};
  logic [4:0] da = 5'h00;
  fpanel_pkg::axil_req_t req = '0;
  fpanel_pkg::axil_rsp_t rsp;
  fpanel_pkg::eng_st_t eng;
  fpanel_pkg::eng_cmd_t cmd;
  fpanel_pkg::leds_t led;
  logic lock = 1'b0;
  logic flt = 1'b0;
  logic hit = 1'b0;
  logic stop_all;
  logic mute;
  logic [NC-1:0] play1, stp, clr, red, grn;
  logic [7:0] ch;
  logic [9:0] pv;
  logic [31:0] rd;
  logic [1:0] rr;
  int n_fail = 0;
  int total_checks = 0;
  int cnt [10];
  int on_r, on_g, skew;

  front_panel #(.NCARD(NC), .DEB_CYC(4), .BLINK_CYC(8)) front_panel_i (
    .CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .BTN_I(btn), .TEST_BTN_I(tbtn), .ENG_I(eng),
    .CARD_ST_I(cst), .DISP_ADDR_I(da), .AXI_REQ_I(req), .AXI_RSP_O(rsp), .LED_O(led),
    .ENG_CMD_O(cmd), .STOP_ALL_O(stop_all), .MUTE_O(mute), .PLAY_FIRST_O(play1), .STOP_O(stp),
    .CLR_FAULT_O(clr), .LAMP_RED_O(red), .LAMP_GRN_O(grn), .DISP_CHAR_O(ch));
  eng_model eng_model_i (.clk_i(clk), .rst_n_i(rst_n), .cmd_i(cmd), .lock_i(lock),
    .fault_i(flt), .hit_i(hit), .st_o(eng));

  // Clock and pulse counting for the engine commands, stop-all and the card 0 command outputs
  initial begin
    forever #2 clk = ~clk;
  end
  assign pv = {clr[0], stp[0], play1[0], stop_all, cmd.ignore, cmd.halt, cmd.pause,
    cmd.restart, cmd.listen, cmd.start};
  always @(posedge clk) begin
    for (int i = 0; i < 10; i++) begin
      cnt[i] += int'(pv[i] === 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [1:0] obs(input int n);
    return (n == 0) ? 2'h0 : (n == 24) ? 2'h1 : 2'h2;
  endfunction
  // One AXI4-Lite transfer; waits for each ready and the answer
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    bit aw;
    bit w;
    @(posedge clk);
    aw = 1'b1;
    w = wr;
    n = 0;
    req.awaddr <= {24'h0, a};
    req.araddr <= {24'h0, a};
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= wr;
    req.wvalid <= wr;
    req.bready <= wr;
    req.arvalid <= !wr;
    req.rready <= !wr;
    while (n < 200) begin
      @(posedge clk);
      n++;
      if (aw && (wr ? rsp.awready : rsp.arready) === 1'b1) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
        req.arvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
      if (wr && rsp.bvalid === 1'b1) begin
        rr = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
      if (!wr && rsp.rvalid === 1'b1) begin
        rr = rsp.rresp;
        rd = rsp.rdata;
        req.rready <= 1'b0;
        break;
      end
    end
    if (n >= 200) begin
      n_fail++;
      complete_run();
    end
  endtask
  // Press and release one button; compare masked pulse counts
  task automatic pr(input int b, input logic [9:0] m, input logic [9:0] e, input string nm);
    logic [9:0] v;
    logic many;
    @(negedge clk);
    foreach (cnt[i]) cnt[i] = 0;
    @(posedge clk);
    if (b < 4) btn[b] <= 1'b1;
    else tbtn[b-4] <= 1'b1;
    cyc(30);
    btn <= 4'h0;
    tbtn <= '0;
    cyc(30);
    many = 1'b0;
    foreach (cnt[i]) begin
      v[i] = (cnt[i] == 1);
      many |= (cnt[i] > 1);
    end
    chk(nm, {many, v & m}, {1'b0, e});
  endtask
  task automatic disp(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    da <= a;
    cyc(2);
    chk("disp_char", ch, e);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(50000);
    n_fail++;
    complete_run();
  end
  initial begin
    cyc(8);
    chk("led_in_reset", led, 9'h100);
    chk("awready_in_reset", rsp.awready, 1'b1);
    cyc(8);
    rst_n <= 1'b1;
    cyc(3);
    chk("led_idle", led, 9'h112);
    axi(0, fpanel_pkg::CTRL_OFS, 0);
    chk("ctrl_reset", rd, 32'h0);
    axi(0, fpanel_pkg::STAT_OFS, 0);
    chk("status", rd, 32'h112);
    axi(0, fpanel_pkg::TIME_OFS, 0);
    chk("time_reg", rd, 32'h01020304);
    axi(0, 8'h0c, 0);
    chk("unmapped", rr, fpanel_pkg::RESP_SLVERR);
    axi(1, fpanel_pkg::STAT_OFS, 32'hffffffff);
    chk("ro_write", rr, fpanel_pkg::RESP_OKAY);
    for (int k = 0; k < 6; k++) begin
      cst <= {NC{rows[k].st}};
      cyc(3);
      on_r = 0;
      on_g = 0;
      skew = 0;
      repeat (24) begin
        @(posedge clk);
        on_r += int'(red[0] === 1'b1);
        on_g += int'(grn[0] === 1'b1);
        skew += int'(red[0] !== red[1] || grn[0] !== grn[1]);
      end
      chk("lamp_red", obs(on_r), rows[k].r);
      chk("lamp_grn", obs(on_g), rows[k].g);
      chk("blink_phase", skew, 0);
      pr(4, 10'h3ff, rows[k].c, "test_btn");
    end
    // Cards back to stopped so no card fault leaks into the unit lamps
    cst <= {NC{fpanel_pkg::CS_STOP}};
    pr(0, 10'h3ff, 10'h001, "start_gen");
    cyc(3);
    chk("led_gen", led, 9'h138);
    disp(5'h00, 8'h47);
    disp(5'h05, 8'h30);
    disp(5'h07, 8'h3a);
    disp(5'h10, 8'h52);
    disp(5'h1e, 8'h32);
    disp(5'h1f, 8'h34);
    pr(0, 10'h3ff, 10'h000, "no_restart");
    axi(1, fpanel_pkg::CTRL_OFS, 32'h4);
    pr(0, 10'h004, 10'h004, "restart");
    pr(1, 10'h008, 10'h000, "pause_noloop");
    chk("pause_led_noloop", led.pause, 1'b0);
    axi(1, fpanel_pkg::CTRL_OFS, 32'h6);
    pr(1, 10'h008, 10'h000, "pause_wait");
    chk("pause_led_pend", led.pause, 1'b1);
    @(posedge clk);
    hit <= 1'b1;
    @(posedge clk);
    hit <= 1'b0;
    cyc(3);
    chk("pause_cmd", cnt[3], 1);
    chk("pause_led_done", {led.pause, led.gen}, 2'h0);
    pr(2, 10'h3ff, 10'h050, "reset_gen");
    chk("stop_led", led.stop, 1'b1);
    disp(5'h05, 8'h2d);
    axi(1, fpanel_pkg::CTRL_OFS, 32'h21);
    axi(0, fpanel_pkg::CTRL_OFS, 0);
    chk("ctrl_rw", rd, 32'h21);
    pr(0, 10'h3ff, 10'h002, "start_read");
    disp(5'h00, 8'h52);
    disp(5'h1e, 8'h33);
    disp(5'h1f, 8'h30);
    pr(2, 10'h3ff, 10'h060, "reset_read");
    axi(1, fpanel_pkg::CTRL_OFS, 32'h8);
    @(posedge clk);
    lock <= 1'b1;
    flt <= 1'b1;
    cyc(3);
    chk("vsync_fault_on", {led.vsync, led.fault}, 2'h3);
    disp(5'h03, 8'h2a);
    @(posedge clk);
    lock <= 1'b0;
    flt <= 1'b0;
    cyc(3);
    chk("vsync_fault_off", {led.vsync, led.fault}, 2'h0);
    cst <= {NC{fpanel_pkg::CS_PLAY}};
    pr(3, 10'h3ff, 10'h000, "mute_on");
    chk("muted", {mute, led.mute, red[0], grn[0]}, 4'he);
    pr(3, 10'h3ff, 10'h000, "mute_off");
    chk("unmuted", {mute, led.mute, red[0], grn[0]}, 4'h1);
    complete_run();
  end
endmodule
